// *** design/fdsm_pkg.sv ***
/*
 * Constants for the field diagnostic status mapper: parameter indices,
 * range map layout, reset values, event number bounds and priority limits.
 * Assumes the block runs on one system clock with a synchronous reset.
 */
// Behaviour
// - Each event number falls in sensor 000-199, electronics 200-399, configuration 400-700 or process 800-999.
// - Event groups carry a weighting of highest, high or low, the low one split into two groups.
// - Each of the four status signals owns a 32-bit range map whose set bits report matching events with it.
// - Map bits 31-28 are highest weighting, 27-24 high, 23-20 first low, 19-16 second low, each in range order.
// - After reset failure maps 31-28, check 27-24, off-spec 23-20, maintenance 19-16, all other bits clear.
// - Map bits 15 to 1 are slots tied to single events regardless of range, each clear after reset.
// - A range bit acts on every event of its whole range at once.
// - An event whose bit is clear in all four maps yields no status signal to the host.
// - Multi-bit configuration is off after reset and works only once the host selects it in the feature selection.
// - A change of assignment leaves active events as they were; the new one applies when the event recurs.
// - An event goes onto the bus only when its status signal priority is 2 to 15.
// - Priority 1 events show locally only; priority 0, the reset value, events are ignored.
// - Each status signal has its own independently writable priority.
// - A set broadcast mask bit blocks bus transmission of its events while they stay shown locally.
// - A detection enable per slot and status signal decides whether the slot's event is recorded.
package fdsm_pkg;

  localparam int unsigned FDSM_MAP_W   = 32;
  localparam int unsigned FDSM_NUM_SIG = 4;
  localparam int unsigned FDSM_PRI_W   = 4;
  localparam int unsigned FDSM_ADDR_W  = 5;
  localparam int unsigned FDSM_EVT_W   = 10;
  localparam int unsigned FDSM_SLOT_W  = 4;

  // Status signal order, also bit order of the status and report outputs
  localparam int unsigned FDSM_SIG_FAIL  = 0;
  localparam int unsigned FDSM_SIG_CHECK = 1;
  localparam int unsigned FDSM_SIG_SPEC  = 2;
  localparam int unsigned FDSM_SIG_MAINT = 3;

  // Parameter indices
  localparam logic [4:0] FDSM_IDX_MAP0  = 5'h00;
  localparam logic [4:0] FDSM_IDX_PRI0  = 5'h04;
  localparam logic [4:0] FDSM_IDX_DET0  = 5'h08;
  localparam logic [4:0] FDSM_IDX_MASK0 = 5'h0C;
  localparam logic [4:0] FDSM_IDX_FEAT  = 5'h10;
  localparam logic [4:0] FDSM_IDX_MODE  = 5'h11;
  localparam logic [4:0] FDSM_IDX_ACT0  = 5'h14;
  localparam logic [4:0] FDSM_IDX_STAT  = 5'h18;

  localparam int unsigned FDSM_FEAT_MULTIBIT = 0;
  localparam int unsigned FDSM_MODE_OUT_OF_SERVICE = 0;

  // Default range maps, slot field mask and priority values
  localparam logic [31:0] FDSM_FAIL_MAP_RST  = 32'hF000_0000;
  localparam logic [31:0] FDSM_CHECK_MAP_RST = 32'h0F00_0000;
  localparam logic [31:0] FDSM_SPEC_MAP_RST  = 32'h00F0_0000;
  localparam logic [31:0] FDSM_MAINT_MAP_RST = 32'h000F_0000;
  localparam logic [31:0] FDSM_SLOT_FIELD    = 32'h0000_FFFE;
  localparam logic [3:0]  FDSM_PRI_RST       = 4'h0;
  localparam logic [3:0]  FDSM_PRI_LOCAL     = 4'h1;
  localparam logic [3:0]  FDSM_PRI_BUS_MIN   = 4'h2;

  // Range layout
  localparam logic [4:0] FDSM_BIT_TOP = 5'h1F;

  // Allocation bounds
  localparam logic [9:0] FDSM_SENS_MAX = 10'd199;
  localparam logic [9:0] FDSM_ELEC_MAX = 10'd399;
  localparam logic [9:0] FDSM_CONF_MIN = 10'd400;
  localparam logic [9:0] FDSM_CONF_MAX = 10'd700;
  localparam logic [9:0] FDSM_PROC_MIN = 10'd800;
  localparam logic [9:0] FDSM_PROC_MAX = 10'd999;

  typedef enum logic [1:0] {
    FDSM_ALLOC_SENSOR,
    FDSM_ALLOC_ELEC,
    FDSM_ALLOC_CONF,
    FDSM_ALLOC_PROC
  } fdsm_alloc_e;

  typedef enum logic [1:0] {
    FDSM_WT_HIGHEST,
    FDSM_WT_HIGH,
    FDSM_WT_LOW_A,
    FDSM_WT_LOW_B
  } fdsm_weight_e;

endpackage : fdsm_pkg

// *** design/fdsm_range_decoder.sv ***
/*
 * Turns an event number, its weighting and an optional slot into the
 * index of the map bit that governs it.
 * Assumes slot 0 means the event is handled by its range.
 */
module fdsm_range_decoder
  import fdsm_pkg::*;
(
  input  wire logic [9:0] num_in,    // Event number
  input  wire logic [1:0] weight_in, // Weighting group
  input  wire logic [3:0] slot_in,   // Slot, zero when none
  output logic            hit_out,   // Event maps to a bit
  output logic [4:0]      idx_out    // Map bit index
);

  fdsm_alloc_e alloc;
  logic        in_range;

  always_comb begin
    alloc    = FDSM_ALLOC_SENSOR;
    in_range = 1'b1;
    if (num_in <= FDSM_SENS_MAX) begin
      alloc = FDSM_ALLOC_SENSOR;
    end else if (num_in <= FDSM_ELEC_MAX) begin
      alloc = FDSM_ALLOC_ELEC;
    end else if (num_in >= FDSM_CONF_MIN && num_in <= FDSM_CONF_MAX) begin
      alloc = FDSM_ALLOC_CONF;
    end else if (num_in >= FDSM_PROC_MIN && num_in <= FDSM_PROC_MAX) begin
      alloc = FDSM_ALLOC_PROC;
    end else begin
      in_range = 1'b0;
    end
  end

  always_comb begin
    if (slot_in != 4'h0) begin
      hit_out = 1'b1;
      idx_out = {1'b0, slot_in};
    end else begin
      // Four bits per weighting, top down
      hit_out = in_range;
      idx_out = FDSM_BIT_TOP - {1'b0, weight_in, 2'b00} - {3'b000, alloc};
    end
  end

endmodule : fdsm_range_decoder

// *** design/fdsm_signal_gate.sv ***
/*
 * Per status signal gating: active vector, local indication and bus release.
 * Assumes the captured assignment vector already holds the map at occurrence.
 */
module fdsm_signal_gate
  import fdsm_pkg::*;
(
  input  wire logic [31:0] act_in,    // Active range and slot bits
  input  wire logic [31:0] cap_in,    // Assignment caught at occurrence
  input  wire logic [31:0] mask_in,   // Broadcast suppression mask
  input  wire logic [3:0]  pri_in,    // Signal priority
  output logic [31:0]      vec_out,   // Active event vector
  output logic             local_out, // Shown locally
  output logic             bus_out    // Reported on the bus
);

  assign vec_out   = act_in & cap_in;
  assign local_out = (|vec_out) && (pri_in != FDSM_PRI_RST);
  assign bus_out   = (|(vec_out & ~mask_in)) && (pri_in >= FDSM_PRI_BUS_MIN);

endmodule : fdsm_signal_gate

// *** design/fdsm_top.sv ***
/*
 * Diagnostic status mapper: records diagnostic events, assigns them to the
 * failure, check, off-spec and maintenance signals through range maps, and
 * decides local display and bus transmission per signal.
 * Assumes events come from logic on the same clock; parameters are written
 * and read over the resource block parameter port.
 */
module fdsm_top
  import fdsm_pkg::*;
(
  input  wire logic        clk_sys_in,        // System clock, 200 MHz
  input  wire logic        rst_b_in,          // Synchronous reset, active low
  input  wire logic        evt_set_in,        // Event occurs, pulse
  input  wire logic        evt_clr_in,        // Event goes away, pulse
  input  wire logic [9:0]  evt_num_in,        // Event number
  input  wire logic [1:0]  evt_weight_in,     // Event weighting group
  input  wire logic [3:0]  evt_slot_in,       // Tied slot, zero when none
  input  wire logic        cfg_wr_in,         // Parameter write strobe
  input  wire logic        cfg_rd_in,         // Parameter read strobe
  input  wire logic [4:0]  cfg_idx_in,        // Parameter index
  input  wire logic [31:0] cfg_wdata_in,      // Parameter write data
  output logic [31:0]      cfg_rdata_out,     // Parameter read data
  output logic             cfg_ack_out,       // Access done, pulse
  output logic             cfg_refused_out,   // Write refused, pulse
  output logic [3:0]       status_local_out,  // Signals shown locally
  output logic [3:0]       status_bus_out,    // Signals reported to host
  output logic             tx_valid_out,      // New bus report, pulse
  output logic [3:0]       tx_status_out,     // Signals of the report
  output logic [9:0]       tx_event_num_out   // Event of the report
);

  logic [3:0][31:0] map_r;
  logic [3:0][3:0]  pri_r;
  logic [3:0][31:0] det_r;
  logic [3:0][31:0] mask_r;
  logic [3:0][31:0] cap_r;
  logic [31:0]      act_r;
  logic             multibit_r;
  logic             out_of_service_r;
  logic [3:0][31:0] eff_map;
  logic [3:0][31:0] vec;
  logic [3:0]       sig_local;
  logic [3:0]       sig_bus;
  logic             set_hit;
  logic [4:0]       set_idx;
  logic             clr_hit;
  logic [4:0]       clr_idx;
  logic             set_take;
  logic [3:0]       new_cap;
  logic [3:0]       new_bus;
  logic             wr_map;
  logic             wr_refused;
  logic [31:0]      rd_nxt;
  logic [1:0]       sel;

  localparam logic [3:0][31:0] MAP_RST = {FDSM_MAINT_MAP_RST, FDSM_SPEC_MAP_RST,
                                          FDSM_CHECK_MAP_RST, FDSM_FAIL_MAP_RST};

  assign sel = cfg_idx_in[1:0];

  fdsm_range_decoder u_set_dec (
    .num_in    (evt_num_in),
    .weight_in (evt_weight_in),
    .slot_in   (evt_slot_in),
    .hit_out   (set_hit),
    .idx_out   (set_idx)
  );

  fdsm_range_decoder u_clr_dec (
    .num_in    (evt_num_in),
    .weight_in (evt_weight_in),
    .slot_in   (evt_slot_in),
    .hit_out   (clr_hit),
    .idx_out   (clr_idx)
  );

  // Maps in force; defaults while multi-bit is off
  always_comb begin
    for (int s = 0; s < FDSM_NUM_SIG; s++) begin
      eff_map[s] = multibit_r ? map_r[s] : MAP_RST[s];
    end
  end

  // Assignment of the new event, per signal
  always_comb begin
    for (int s = 0; s < FDSM_NUM_SIG; s++) begin
      if (evt_slot_in != 4'h0) begin
        new_cap[s] = eff_map[s][set_idx] & det_r[s][set_idx];
      end else begin
        new_cap[s] = eff_map[s][set_idx];
      end
      new_bus[s] = new_cap[s] && !mask_r[s][set_idx]
                   && (pri_r[s] >= FDSM_PRI_BUS_MIN);
    end
  end

  assign set_take = evt_set_in && set_hit;

  // Active bits; an occurrence wins over a clear of the same bit
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      act_r <= '0;
    end else begin
      for (int b = 1; b < FDSM_MAP_W; b++) begin
        if (set_take && set_idx == 5'(b)) begin
          act_r[b] <= 1'b1;
        end else if (evt_clr_in && clr_hit && clr_idx == 5'(b)) begin
          act_r[b] <= 1'b0;
        end
      end
      act_r[0] <= 1'b0;
    end
  end

  // Assignment is caught only at occurrence
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cap_r <= '0;
    end else if (set_take) begin
      for (int s = 0; s < FDSM_NUM_SIG; s++) begin
        cap_r[s][set_idx] <= new_cap[s];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < FDSM_NUM_SIG; g++) begin : g_sig
      fdsm_signal_gate u_gate (
        .act_in    (act_r),
        .cap_in    (cap_r[g]),
        .mask_in   (mask_r[g]),
        .pri_in    (pri_r[g]),
        .vec_out   (vec[g]),
        .local_out (sig_local[g]),
        .bus_out   (sig_bus[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      status_local_out <= '0;
      status_bus_out   <= '0;
    end else begin
      status_local_out <= sig_local;
      status_bus_out   <= sig_bus;
    end
  end

  // One report per occurrence that reaches the bus
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_valid_out     <= 1'b0;
      tx_status_out    <= '0;
      tx_event_num_out <= '0;
    end else begin
      tx_valid_out <= set_take && (|new_bus);
      if (set_take && (|new_bus)) begin
        tx_status_out    <= new_bus;
        tx_event_num_out <= evt_num_in;
      end
    end
  end

  // Maps change only with multi-bit on and the block out of service
  assign wr_map     = cfg_wr_in && (cfg_idx_in[4:2] == FDSM_IDX_MAP0[4:2]);
  assign wr_refused = wr_map && !(multibit_r && out_of_service_r);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      map_r <= MAP_RST;
    end else if (wr_map && !wr_refused) begin
      map_r[sel] <= cfg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      pri_r <= {FDSM_NUM_SIG{FDSM_PRI_RST}};
    end else if (cfg_wr_in && cfg_idx_in[4:2] == FDSM_IDX_PRI0[4:2]) begin
      pri_r[sel] <= cfg_wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      det_r <= '0;
    end else if (cfg_wr_in && cfg_idx_in[4:2] == FDSM_IDX_DET0[4:2]) begin
      det_r[sel] <= cfg_wdata_in & FDSM_SLOT_FIELD;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      mask_r <= '0;
    end else if (cfg_wr_in && cfg_idx_in[4:2] == FDSM_IDX_MASK0[4:2]) begin
      mask_r[sel] <= cfg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      multibit_r <= 1'b0;
    end else if (cfg_wr_in && cfg_idx_in == FDSM_IDX_FEAT) begin
      multibit_r <= cfg_wdata_in[FDSM_FEAT_MULTIBIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      out_of_service_r <= 1'b0;
    end else if (cfg_wr_in && cfg_idx_in == FDSM_IDX_MODE) begin
      out_of_service_r <= cfg_wdata_in[FDSM_MODE_OUT_OF_SERVICE];
    end
  end

  // Read mux; unknown indices read zero
  always_comb begin
    rd_nxt = '0;
    case (cfg_idx_in[4:2])
      FDSM_IDX_MAP0[4:2]:  rd_nxt = map_r[sel];
      FDSM_IDX_PRI0[4:2]:  rd_nxt = {28'h000_0000, pri_r[sel]};
      FDSM_IDX_DET0[4:2]:  rd_nxt = det_r[sel];
      FDSM_IDX_MASK0[4:2]: rd_nxt = mask_r[sel];
      FDSM_IDX_ACT0[4:2]:  rd_nxt = vec[sel];
      default: begin
        if (cfg_idx_in == FDSM_IDX_FEAT) begin
          rd_nxt = {31'h0000_0000, multibit_r};
        end else if (cfg_idx_in == FDSM_IDX_MODE) begin
          rd_nxt = {31'h0000_0000, out_of_service_r};
        end else if (cfg_idx_in == FDSM_IDX_STAT) begin
          rd_nxt = {24'h00_0000, sig_bus, sig_local};
        end else begin
          rd_nxt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cfg_rdata_out   <= '0;
      cfg_ack_out     <= 1'b0;
      cfg_refused_out <= 1'b0;
    end else begin
      cfg_ack_out     <= cfg_wr_in || cfg_rd_in;
      cfg_refused_out <= wr_refused;
      if (cfg_rd_in) begin
        cfg_rdata_out <= rd_nxt;
      end
    end
  end

endmodule : fdsm_top

// *** test/fdsm_chk.sv ***
/* Port checker for fdsm_top: parameter port handshake and report timing.
   Assumes one clock and the synchronous active-low reset. */
module fdsm_chk
(
  input wire logic       clk_sys_in,       // Clock
  input wire logic       rst_b_in,         // Reset
  input wire logic       evt_set_in,       // Occurrence
  input wire logic [9:0] evt_num_in,       // Event number
  input wire logic       cfg_wr_in,        // Write
  input wire logic       cfg_rd_in,        // Read
  input wire logic [4:0] cfg_idx_in,       // Index
  input wire logic       cfg_ack_out,      // Ack
  input wire logic       cfg_refused_out,  // Refused
  input wire logic [3:0] status_local_out, // Local
  input wire logic [3:0] status_bus_out,   // Bus
  input wire logic       tx_valid_out,     // Report
  input wire logic [3:0] tx_status_out,    // Report signals
  input wire logic [9:0] tx_event_num_out  // Report event
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_ack;
    cfg_wr_in || cfg_rd_in |=> cfg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle;
    !(cfg_wr_in || cfg_rd_in) |=> !cfg_ack_out; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_refuse;
    cfg_refused_out |-> $past(cfg_wr_in) && $past(cfg_idx_in) < 5'h04; endproperty
  a_refuse: assert property (p_refuse) else $error("bad refusal");
  property p_keep;
    cfg_wr_in && cfg_idx_in >= 5'h04 |=> !cfg_refused_out; endproperty
  a_keep: assert property (p_keep) else $error("refused non-map");
  property p_shown;
    (status_bus_out & ~status_local_out) == 4'h0; endproperty
  a_shown: assert property (p_shown) else $error("bus not shown");
  property p_src;
    tx_valid_out |-> $past(evt_set_in) && tx_event_num_out == $past(evt_num_in); endproperty
  a_src: assert property (p_src) else $error("report source");
  property p_nz;
    tx_valid_out |-> tx_status_out != 4'h0; endproperty
  a_nz: assert property (p_nz) else $error("empty report");
  property p_bus;
    tx_valid_out |=> (status_bus_out & tx_status_out) == tx_status_out; endproperty
  a_bus: assert property (p_bus) else $error("report not on bus");
  c_ref: cover property (cfg_refused_out);
  c_tx: cover property (tx_valid_out);
  c_loc: cover property (status_local_out != status_bus_out);
endmodule : fdsm_chk
bind fdsm_top fdsm_chk u_chk (.clk_sys_in, .rst_b_in, .evt_set_in, .evt_num_in, .cfg_wr_in, .cfg_rd_in,
  .cfg_idx_in, .cfg_ack_out, .cfg_refused_out, .status_local_out, .status_bus_out, .tx_valid_out,
  .tx_status_out, .tx_event_num_out);

// *** test/fdsm_host_model.sv ***
/* Host model: configuration tool on the parameter port.
   Assumes the bench calls access() and reads rdata and refused after. */
module fdsm_host_model
(
  input  wire logic        clk_sys_in,    // Clock
  output logic             cfg_wr_out,    // Write strobe
  output logic             cfg_rd_out,    // Read strobe
  output logic [4:0]       cfg_idx_out,   // Index
  output logic [31:0]      cfg_wdata_out, // Write data
  input  wire logic [31:0] cfg_rdata_in,  // Read data
  input  wire logic        cfg_ack_in,    // Ack
  input  wire logic        cfg_refused_in // Refused
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata;
  logic        refused;
  initial begin
    {cfg_wr_out, cfg_rd_out, cfg_idx_out, cfg_wdata_out} = '0;
  end
  task automatic access(input logic wr, input logic [4:0] idx, input logic [31:0] d);
    @(negedge clk_sys_in);
    cfg_wr_out = wr;
    cfg_rd_out = !wr;
    cfg_idx_out = idx;
    cfg_wdata_out = d;
    @(negedge clk_sys_in);
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_idx_out = ~idx;
    cfg_wdata_out = ~d;
    // No ack leaves the reply unknown
    rdata = cfg_ack_in === 1'b1 ? cfg_rdata_in : 'x;
    refused = cfg_ack_in === 1'b1 ? cfg_refused_in : 1'bx;
  endtask : access
endmodule : fdsm_host_model

// *** test/test_field_diag_status_mapper.sv ***
/* Bench for fdsm_top with a reference model of maps, priorities, masks and slots.
   Assumes fdsm_host_model drives the parameter port. */
module test_field_diag_status_mapper
  import fdsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in, rst_b_in, evt_set_in, evt_clr_in, cfg_wr_in, cfg_rd_in, cfg_ack_out;
  logic        cfg_refused_out, tx_valid_out;
  logic [9:0]  evt_num_in, tx_event_num_out;
  logic [1:0]  evt_weight_in;
  logic [3:0]  evt_slot_in, status_local_out, status_bus_out, tx_status_out;
  logic [4:0]  cfg_idx_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, m_reg[32], m_vec[4];
  int          bad_count = 0, tests_run = 0, n;
  fdsm_host_model u_host (.clk_sys_in, .cfg_wr_out(cfg_wr_in), .cfg_rd_out(cfg_rd_in), .cfg_idx_out(cfg_idx_in),
    .cfg_wdata_out(cfg_wdata_in), .cfg_rdata_in(cfg_rdata_out), .cfg_ack_in(cfg_ack_out),
    .cfg_refused_in(cfg_refused_out));
  fdsm_top u_dut (.clk_sys_in, .rst_b_in, .evt_set_in, .evt_clr_in, .evt_num_in, .evt_weight_in, .evt_slot_in,
    .cfg_wr_in, .cfg_rd_in, .cfg_idx_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_ack_out, .cfg_refused_out,
    .status_local_out, .status_bus_out, .tx_valid_out, .tx_status_out, .tx_event_num_out);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  function automatic logic [7:0] exp_st();
    logic [7:0] r;
    r = 8'h00;
    for (int s = 0; s < 4; s++) begin
      r[s] = m_vec[s] != 0 && m_reg[4 + s] != 0;
      r[4 + s] = (m_vec[s] & ~m_reg[12 + s]) != 0 && m_reg[4 + s] >= 2;
    end
    return r;
  endfunction : exp_st
  function automatic logic [31:0] exp_rd(input int idx);
    if (idx >= 20 && idx < 24) return m_vec[idx - 20];
    if (idx == 24) return {24'h00_0000, exp_st()};
    return m_reg[idx];
  endfunction : exp_rd
  function automatic int bit_of(input int num, input int w, input int slot);
    if (slot != 0) return slot;
    if (num > 999 || (num > 700 && num < 800)) return -1;
    return 31 - 4 * w - (num < 200 ? 0 : num < 400 ? 1 : num <= 700 ? 2 : 3);
  endfunction : bit_of
  task automatic cfg(input int idx, input logic [31:0] d);
    logic ok;
    ok = idx >= 4 || (m_reg[16][0] && m_reg[17][0]);
    u_host.access(1'b1, idx[4:0], d);
    check(u_host.refused, !ok);
    if (ok) m_reg[idx] = (idx >= 8 && idx < 12) ? d & 32'h0000_FFFE : d;
    u_host.access(1'b0, idx[4:0], 32'h0);
    check(u_host.rdata, m_reg[idx]);
  endtask : cfg
  task automatic remap(input int s, input logic [31:0] d);
    cfg(17, 32'h1);
    cfg(s, d);
    cfg(17, 32'h0);
  endtask : remap
  task automatic evt(input logic set, input int num, input int w, input int slot);
    int b;
    logic [3:0] tx;
    logic [31:0] mp;
    b = bit_of(num, w, slot);
    tx = 4'h0;
    for (int s = 0; s < 4; s++) begin
      mp = m_reg[16][0] ? m_reg[s] : 32'hF000_0000 >> (4 * s);
      if (b > 0 && !set) m_vec[s][b] = 1'b0;
      if (b > 0 && set) m_vec[s][b] = mp[b] && (slot == 0 || m_reg[8 + s][b]);
      if (b > 0 && set && m_vec[s][b] && !m_reg[12 + s][b] && m_reg[4 + s] >= 2) tx[s] = 1'b1;
    end
    @(negedge clk_sys_in);
    evt_set_in = set;
    evt_clr_in = !set;
    evt_num_in = num[9:0];
    evt_weight_in = w[1:0];
    evt_slot_in = slot[3:0];
    @(negedge clk_sys_in);
    evt_set_in = 1'b0;
    evt_clr_in = 1'b0;
    check(tx_valid_out, tx != 0);
    if (tx != 0) check({tx_status_out, tx_event_num_out}, {tx, num[9:0]});
    @(negedge clk_sys_in);
    check({status_bus_out, status_local_out}, exp_st());
  endtask : evt
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  initial begin : watchdog
    #50us;
    bad_count++;
    tally_and_finish();
  end
  initial begin : main
    int lo[4];
    lo = '{0, 200, 400, 800};
    {evt_set_in, evt_clr_in, evt_num_in, evt_weight_in, evt_slot_in, rst_b_in} = '0;
    foreach (m_reg[i]) m_reg[i] = i < 4 ? 32'hF000_0000 >> (4 * i) : 32'h0;
    foreach (m_vec[i]) m_vec[i] = 32'h0;
    void'($urandom(32'hB13D));
    repeat (16) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    for (int i = 0; i < 25; i++) begin
      u_host.access(1'b0, i[4:0], 32'h0);
      check(u_host.rdata, exp_rd(i));
    end
    $display("Test reset values done");
    cfg(4, 32'h2);
    cfg(5, 32'h1);
    cfg(6, 32'hF);
    cfg(0, 32'h0);
    for (int w = 0; w < 4; w++) begin
      for (int a = 0; a < 4; a++) begin
        n = lo[a] + $urandom % 200;
        evt(1'b1, n, w, 0);
        evt(1'b0, n, w, 0);
      end
    end
    evt(1'b1, 701 + $urandom % 99, 0, 0);
    $display("Test ranges and priorities done");
    cfg(16, 32'h1);
    cfg(1, 32'h0);
    evt(1'b1, 250, 0, 0);
    remap(0, 32'h3000_0000);
    remap(1, 32'h4F00_0000);
    cfg(5, 32'h3);
    check({status_bus_out, status_local_out}, exp_st());
    evt(1'b1, 399, 0, 0);
    evt(1'b0, 399, 0, 0);
    evt(1'b1, 50, 0, 0);
    $display("Test remap done");
    cfg(12, 32'h1000_0000);
    evt(1'b1, 900, 0, 0);
    evt(1'b0, 900, 0, 0);
    remap(2, 32'h00F0_0020);
    evt(1'b1, 123, 3, 5);
    cfg(10, 32'hFFFF_FFFF);
    evt(1'b1, 123, 3, 5);
    $display("Test mask and slots done");
    for (int i = 20; i < 25; i++) begin
      u_host.access(1'b0, i[4:0], 32'h0);
      check(u_host.rdata, exp_rd(i));
    end
    $display("Test vector readback done");
    tally_and_finish();
  end
endmodule : test_field_diag_status_mapper
